// *** design/jbs_pkg.sv ***
package jbs_pkg;

  localparam int IR_LEN = 10;
  localparam int WORD_LEN = 32;
  localparam int SIG_LEN = 16;
  localparam int ISP_LEN = 16;
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int BSR_LEN_DEFAULT = 96;

  localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h055;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h059;
  localparam logic [IR_LEN-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_LEN-1:0] OP_SIGNATURE = 10'h079;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3FF;
  localparam logic [1:0] ISP_GROUP = 2'h2;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;

  // identity fields; values are arbitrary
  localparam logic [3:0] ID_VERSION = 4'h3;
  localparam logic [15:0] ID_PART = 16'hA5C3;
  localparam logic [10:0] ID_MAKER = 11'h155;
  localparam logic ID_MARK = 1'b1;

  typedef enum logic [3:0] {
    TAP_RESET = 4'hF,
    TAP_IDLE = 4'hC,
    TAP_SEL_DR = 4'h7,
    TAP_CAP_DR = 4'h6,
    TAP_SH_DR = 4'h2,
    TAP_EX1_DR = 4'h1,
    TAP_PAU_DR = 4'h3,
    TAP_EX2_DR = 4'h0,
    TAP_UPD_DR = 4'h5,
    TAP_SEL_IR = 4'h4,
    TAP_CAP_IR = 4'hE,
    TAP_SH_IR = 4'hA,
    TAP_EX1_IR = 4'h9,
    TAP_PAU_IR = 4'hB,
    TAP_EX2_IR = 4'h8,
    TAP_UPD_IR = 4'hD
  } jbs_tap_state_t;

  typedef enum logic [2:0] {
    PATH_BYPASS = 3'h0,
    PATH_BSR = 3'h1,
    PATH_ID = 3'h2,
    PATH_USER = 3'h3,
    PATH_SIG = 3'h4,
    PATH_ISP = 3'h5
  } jbs_path_t;

endpackage

// *** design/jbs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] hold;
  } jbs_sync_state_t;

  jbs_sync_state_t s;
  jbs_sync_state_t next_s;

  always_comb begin
    next_s.meta = d;
    next_s.hold = s.meta;
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign q = s.hold;
endmodule
`default_nettype wire

// *** design/jbs_tap_fsm.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbs_tap_fsm
  import jbs_pkg::*;
(
  input wire logic tck,
  input wire logic tap_rst_n,
  input wire logic tms,
  output jbs_tap_state_t state
);
  typedef struct packed {
    jbs_tap_state_t st;
  } jbs_fsm_state_t;

  jbs_fsm_state_t s;
  jbs_fsm_state_t next_s;

  always_comb begin
    next_s = s;
    case (s.st)
      TAP_RESET: next_s.st = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_s.st = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_s.st = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_s.st = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_s.st = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_s.st = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_s.st = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_s.st = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_s.st = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_s.st = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_s.st = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_s.st = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_s.st = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_s.st = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_s.st = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_s.st = tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_s.st = TAP_RESET;
    endcase
    if (!tap_rst_n) begin
      next_s.st = TAP_RESET;
    end
  end

  always_ff @(posedge tck) begin
    s <= next_s;
  end

  assign state = s.st;
endmodule
`default_nettype wire

// *** design/jbs_tap_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbs_tap_top
  import jbs_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEFAULT,
  parameter bit HAS_USERCODE = 1'b1,
  parameter bit HAS_SIGNATURE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic port_en,
  input wire logic user_tdo_out,
  input wire logic user_tdo_oe,
  output logic user_tck_in,
  output logic user_tms_in,
  output logic user_tdi_in,
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] pad_in,
  output logic [BSR_LEN/CELLS_PER_PIN-1:0] pad_out,
  output logic [BSR_LEN/CELLS_PER_PIN-1:0] pad_oe,
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] core_out,
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] core_oe,
  output logic [BSR_LEN/CELLS_PER_PIN-1:0] core_in,
  input wire logic [WORD_LEN-1:0] user_code_word,
  input wire logic [SIG_LEN-1:0] signature_word,
  output logic isp_mode,
  output logic [IR_LEN-1:0] isp_opcode,
  output logic [ISP_LEN-1:0] isp_word,
  output logic isp_strobe
);
  localparam int NPIN = BSR_LEN / CELLS_PER_PIN;
  localparam int TSYNC_W = 1 + 3 * NPIN + WORD_LEN + SIG_LEN;
  localparam int RSYNC_W = 10 + NPIN;

  // link-side state, on tck
  typedef struct packed {
    logic [IR_LEN-1:0] ir_sh;
    logic [IR_LEN-1:0] ir;
    logic [BSR_LEN-1:0] bsr;
    logic [NPIN-1:0] upd_out;
    logic [NPIN-1:0] upd_oe;
    logic byp;
    logic [WORD_LEN-1:0] word;
    logic [ISP_LEN-1:0] isp_hold;
    logic upd_tgl;
    logic isp_tgl;
    logic extest;
    logic isp_on;
  } jbs_tck_state_t;

  // serial output stage, on falling tck
  typedef struct packed {
    logic tdo_bit;
    logic tdo_drv;
  } jbs_neg_state_t;

  // pin-side state, on ref_clk
  typedef struct packed {
    logic hold_n;
    logic tdo_out;
    logic tdo_oe;
    logic [NPIN-1:0] pad_out;
    logic [NPIN-1:0] pad_oe;
    logic [NPIN-1:0] copy_out;
    logic [NPIN-1:0] copy_oe;
    logic upd_prev;
    logic isp_prev;
    logic isp_strobe;
    logic [IR_LEN-1:0] isp_opcode;
    logic [ISP_LEN-1:0] isp_word;
    logic user_tck;
    logic user_tms;
    logic user_tdi;
  } jbs_ref_state_t;

  jbs_tck_state_t t;
  jbs_tck_state_t next_t;
  jbs_neg_state_t g;
  jbs_neg_state_t next_g;
  jbs_ref_state_t r;
  jbs_ref_state_t next_r;

  jbs_tap_state_t tap;
  jbs_path_t path;
  logic [TSYNC_W-1:0] tsync_q;
  logic [RSYNC_W-1:0] rsync_q;

  // tck-side views of crossed levels
  logic tck_rst_n;
  logic [NPIN-1:0] t_pad_in;
  logic [NPIN-1:0] t_core_out;
  logic [NPIN-1:0] t_core_oe;
  logic [WORD_LEN-1:0] t_user_code;
  logic [SIG_LEN-1:0] t_signature;

  // ref-side views of crossed levels
  logic r_tdo_bit;
  logic r_tdo_drv;
  logic r_upd_tgl;
  logic r_isp_tgl;
  logic r_extest;
  logic r_isp_on;
  logic r_port_en;
  logic r_tck;
  logic r_tms;
  logic r_tdi;
  logic [NPIN-1:0] r_pad_in;

  jbs_sync #(
    .WIDTH(TSYNC_W)
  ) u_sync_tck (
    .clk(tck),
    .d({r.hold_n, pad_in, core_out, core_oe, user_code_word, signature_word}),
    .q(tsync_q)
  );

  assign {tck_rst_n, t_pad_in, t_core_out, t_core_oe, t_user_code, t_signature} = tsync_q;

  jbs_sync #(
    .WIDTH(RSYNC_W)
  ) u_sync_ref (
    .clk(ref_clk),
    .d({g.tdo_bit, g.tdo_drv, t.upd_tgl, t.isp_tgl, t.extest, t.isp_on,
        port_en, tck, tms, tdi, pad_in}),
    .q(rsync_q)
  );

  assign {r_tdo_bit, r_tdo_drv, r_upd_tgl, r_isp_tgl, r_extest, r_isp_on,
          r_port_en, r_tck, r_tms, r_tdi, r_pad_in} = rsync_q;

  jbs_tap_fsm u_fsm (
    .tck(tck),
    .tap_rst_n(tck_rst_n),
    .tms(tms),
    .state(tap)
  );

  function automatic jbs_path_t decode(input logic [IR_LEN-1:0] op);
    jbs_path_t p;
    p = PATH_BYPASS;
    if (op == OP_EXTEST || op == OP_SAMPLE) begin
      p = PATH_BSR;
    end else if (op == OP_IDCODE) begin
      p = PATH_ID;
    end else if (op == OP_USERCODE && HAS_USERCODE) begin
      p = PATH_USER;
    end else if (op == OP_SIGNATURE && HAS_SIGNATURE) begin
      p = PATH_SIG;
    end else if (op[IR_LEN-1:IR_LEN-2] == ISP_GROUP) begin
      p = PATH_ISP;
    end
    return p;
  endfunction

  assign path = decode(t.ir);

  always_comb begin
    next_t = t;
    case (tap)
      TAP_RESET: begin
        next_t.ir = OP_IDCODE;
      end
      TAP_CAP_IR: begin
        next_t.ir_sh = IR_CAPTURE;
      end
      TAP_SH_IR: begin
        next_t.ir_sh = {tdi, t.ir_sh[IR_LEN-1:1]};
      end
      TAP_UPD_IR: begin
        next_t.ir = t.ir_sh;
      end
      TAP_CAP_DR: begin
        case (path)
          PATH_BSR: begin
            for (int i = 0; i < NPIN; i++) begin
              next_t.bsr[i * CELLS_PER_PIN + CELL_IN] = t_pad_in[i];
              next_t.bsr[i * CELLS_PER_PIN + CELL_OUT] = t_core_out[i];
              next_t.bsr[i * CELLS_PER_PIN + CELL_OE] = t_core_oe[i];
            end
          end
          PATH_ID: begin
            next_t.word = {ID_VERSION, ID_PART, ID_MAKER, ID_MARK};
          end
          PATH_USER: begin
            next_t.word = t_user_code;
          end
          PATH_SIG: begin
            next_t.word = {{(WORD_LEN - SIG_LEN){1'b0}}, t_signature};
          end
          PATH_ISP: begin
            next_t.word = {{(WORD_LEN - ISP_LEN){1'b0}}, t.isp_hold};
          end
          default: begin
            next_t.byp = 1'b0;
          end
        endcase
      end
      TAP_SH_DR: begin
        case (path)
          PATH_BSR: begin
            next_t.bsr = {tdi, t.bsr[BSR_LEN-1:1]};
          end
          PATH_ID, PATH_USER: begin
            next_t.word = {tdi, t.word[WORD_LEN-1:1]};
          end
          PATH_SIG, PATH_ISP: begin
            next_t.word = {{(WORD_LEN - SIG_LEN){1'b0}}, tdi, t.word[SIG_LEN-1:1]};
          end
          default: begin
            next_t.byp = tdi;
          end
        endcase
      end
      TAP_UPD_DR: begin
        if (path == PATH_BSR) begin
          for (int i = 0; i < NPIN; i++) begin
            next_t.upd_out[i] = t.bsr[i * CELLS_PER_PIN + CELL_OUT];
            next_t.upd_oe[i] = t.bsr[i * CELLS_PER_PIN + CELL_OE];
          end
          next_t.upd_tgl = ~t.upd_tgl;
        end else if (path == PATH_ISP) begin
          next_t.isp_hold = t.word[ISP_LEN-1:0];
          next_t.isp_tgl = ~t.isp_tgl;
        end
      end
      default: begin
        next_t.byp = t.byp;
      end
    endcase
    next_t.extest = (next_t.ir == OP_EXTEST);
    next_t.isp_on = (decode(next_t.ir) == PATH_ISP);
    if (!tck_rst_n) begin
      next_t = '0;
      next_t.ir = OP_IDCODE;
    end
  end

  always_ff @(posedge tck) begin
    t <= next_t;
  end

  // serial out is launched on the falling edge
  always_comb begin
    next_g.tdo_drv = (tap == TAP_SH_IR) || (tap == TAP_SH_DR);
    if (tap == TAP_SH_IR) begin
      next_g.tdo_bit = t.ir_sh[0];
    end else begin
      case (path)
        PATH_BSR: next_g.tdo_bit = t.bsr[0];
        PATH_ID, PATH_USER, PATH_SIG, PATH_ISP: next_g.tdo_bit = t.word[0];
        default: next_g.tdo_bit = t.byp;
      endcase
    end
    if (!tck_rst_n) begin
      next_g = '0;
    end
  end

  always_ff @(negedge tck) begin
    g <= next_g;
  end

  always_comb begin
    next_r = r;
    next_r.hold_n = rst_n & r_port_en;
    next_r.upd_prev = r_upd_tgl;
    next_r.isp_prev = r_isp_tgl;
    next_r.isp_strobe = 1'b0;
    if (r_upd_tgl != r.upd_prev) begin
      next_r.copy_out = t.upd_out;
      next_r.copy_oe = t.upd_oe;
    end
    if (r_isp_tgl != r.isp_prev) begin
      next_r.isp_word = t.isp_hold;
      next_r.isp_opcode = t.ir;
      next_r.isp_strobe = 1'b1;
    end
    if (r_extest) begin
      next_r.pad_out = r.copy_out;
      next_r.pad_oe = r.copy_oe;
    end else begin
      next_r.pad_out = core_out;
      next_r.pad_oe = core_oe;
    end
    if (r_isp_on) begin
      next_r.pad_oe = '0;
    end
    if (r_port_en) begin
      next_r.tdo_out = r_tdo_bit;
      next_r.tdo_oe = r_tdo_drv;
    end else begin
      next_r.tdo_out = user_tdo_out;
      next_r.tdo_oe = user_tdo_oe;
    end
    next_r.user_tck = r_tck & ~r_port_en;
    next_r.user_tms = r_tms & ~r_port_en;
    next_r.user_tdi = r_tdi & ~r_port_en;
    if (!rst_n) begin
      next_r = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    r <= next_r;
  end

  assign tdo_out = r.tdo_out;
  assign tdo_oe = r.tdo_oe;
  assign user_tck_in = r.user_tck;
  assign user_tms_in = r.user_tms;
  assign user_tdi_in = r.user_tdi;
  assign pad_out = r.pad_out;
  assign pad_oe = r.pad_oe;
  assign core_in = r_pad_in;
  assign isp_mode = r_isp_on;
  assign isp_opcode = r.isp_opcode;
  assign isp_word = r.isp_word;
  assign isp_strobe = r.isp_strobe;
endmodule
`default_nettype wire

// *** test/jbs_tap_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbs_tap_checker
  import jbs_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic port_en,
  input wire logic user_tdo_out,
  input wire logic user_tdo_oe,
  input wire logic user_tck_in,
  input wire logic user_tms_in,
  input wire logic user_tdi_in,
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] pad_in,
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] pad_oe,
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] core_in,
  input wire logic isp_mode,
  input wire logic [IR_LEN-1:0] isp_opcode,
  input wire logic isp_strobe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic tck_q;
  logic [2:0] since;
  logic [3:0] en_cnt;
  // cycles since tck seen falling, and cycles with the port enabled
  always_ff @(posedge ref_clk) begin
    tck_q <= tck;
    if (tck_q && !tck) since <= 3'h0;
    else if (since != 3'h7) since <= since + 3'h1;
    if (!rst_n || !port_en) en_cnt <= 4'h0;
    else if (en_cnt != 4'hF) en_cnt <= en_cnt + 4'h1;
  end
  sequence s_port_off;
    !port_en [*5];
  endsequence
  sequence s_port_on;
    port_en [*6];
  endsequence
  property p_user_tdo;
    s_port_off |=> tdo_out == $past(user_tdo_out) && tdo_oe == $past(user_tdo_oe);
  endproperty
  a_user_tdo: assert property (p_user_tdo)
    else $error("tdo pin not driven by core while port off");
  property p_user_pins;
    s_port_off ##1 !port_en |-> user_tck_in == $past(tck, 3) && user_tms_in == $past(tms, 3)
      && user_tdi_in == $past(tdi, 3);
  endproperty
  a_user_pins: assert property (p_user_pins)
    else $error("port pins not passed to core");
  property p_pins_quiet;
    s_port_on |-> !user_tck_in && !user_tms_in;
  endproperty
  a_pins_quiet: assert property (p_pins_quiet)
    else $error("port pins leak to core while port on");
  property p_core_in;
    $past(rst_n, 3) |-> core_in == $past(pad_in, 2);
  endproperty
  a_core_in: assert property (p_core_in)
    else $error("core input path disturbed");
  property p_isp_float;
    isp_mode && $past(isp_mode) |-> pad_oe == '0;
  endproperty
  a_isp_float: assert property (p_isp_float)
    else $error("pads driven while programming");
  property p_strobe_pulse;
    isp_strobe |=> !isp_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("programming strobe longer than one cycle");
  property p_strobe_mode;
    isp_strobe |-> isp_mode && isp_opcode[9:8] == ISP_GROUP;
  endproperty
  a_strobe_mode: assert property (p_strobe_mode)
    else $error("programming strobe outside programming opcode");
  property p_tdo_launch;
    en_cnt == 4'hF && $changed(tdo_out) |-> since <= 3'h5;
  endproperty
  a_tdo_launch: assert property (p_tdo_launch)
    else $error("tdo changed away from falling tck");
  property p_reset_quiet;
    $rose(rst_n) |-> !tdo_oe && pad_oe == '0 && !isp_strobe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active out of reset");
endmodule
bind jbs_tap_top jbs_tap_checker #(.BSR_LEN(BSR_LEN)) u_jbs_tap_checker (.ref_clk, .rst_n,
  .tck, .tms, .tdi, .tdo_out, .tdo_oe, .port_en, .user_tdo_out, .user_tdo_oe, .user_tck_in,
  .user_tms_in, .user_tdi_in, .pad_in, .pad_oe, .core_in, .isp_mode, .isp_opcode,
  .isp_strobe);
`default_nettype wire

// *** test/jbs_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbs_master (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  logic last_q = 1'b0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period; tdo taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #17.3;
    q = tdo_oe ? tdo_out : ~last_q;
    last_q = q;
    #0.9;
    tck = 1'b1;
    #13.8;
    tck = 1'b0;
  endtask
  task automatic tap_reset();
    logic q;
    #0.7;
    repeat (8) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    #0.7;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule
`default_nettype wire

// *** test/jbs_tap_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module jbs_tap_top_tb;
  import jbs_pkg::*;
  localparam int NPIN = BSR_LEN_DEFAULT / CELLS_PER_PIN;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic port_en = 1'b0;
  logic user_tdo_out = 1'b0;
  logic user_tdo_oe = 1'b0;
  logic tck, tms, tdi, tdo_out, tdo_oe, user_tck_in, user_tms_in, user_tdi_in;
  logic isp_mode, isp_strobe;
  logic [NPIN-1:0] pad_in = '0;
  logic [NPIN-1:0] core_out = '0;
  logic [NPIN-1:0] core_oe = '0;
  logic [NPIN-1:0] pad_out, pad_oe, core_in;
  logic [WORD_LEN-1:0] user_code_word = '0;
  logic [SIG_LEN-1:0] signature_word = '0;
  logic [IR_LEN-1:0] isp_opcode;
  logic [ISP_LEN-1:0] isp_word;
  logic [31:0] seed = 32'h0001_6E75;
  logic [127:0] din, dout, pre;
  logic [ISP_LEN-1:0] isp_q [$];
  logic [IR_LEN-1:0] ops [4] = '{OP_USERCODE, OP_SIGNATURE, OP_BYPASS, 10'h123};
  int lens [4] = '{WORD_LEN, SIG_LEN, 8, 8};
  int n_mismatch = 0;
  int checked = 0;
  int strobes = 0;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (isp_strobe === 1'b1) strobes <= strobes + 1;

  jbs_tap_top #(.BSR_LEN(BSR_LEN_DEFAULT)) u_jbs_tap_top (.ref_clk, .rst_n, .tck, .tms, .tdi,
    .tdo_out, .tdo_oe, .port_en, .user_tdo_out, .user_tdo_oe, .user_tck_in, .user_tms_in,
    .user_tdi_in, .pad_in, .pad_out, .pad_oe, .core_out, .core_oe, .core_in, .user_code_word,
    .signature_word, .isp_mode, .isp_opcode, .isp_word, .isp_strobe);
  jbs_master u_jbs_master (.tck, .tms, .tdi, .tdo_out, .tdo_oe);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic load_ir(input logic [IR_LEN-1:0] op);
    u_jbs_master.scan(1'b1, IR_LEN, 128'(op), dout);
    check(dout, 128'(IR_CAPTURE), "ir capture");
    check(128'(tdo_oe), 128'h0, "tdo idle");
  endtask
  task automatic dr(input int n);
    din = {rnd(), rnd(), rnd(), rnd()};
    u_jbs_master.scan(1'b0, n, din, dout);
    din = din & ((128'h1 << n) - 128'h1);
  endtask
  // expected capture image: pin level, core drive, core enable per pin
  function automatic logic [127:0] cap();
    logic [127:0] v = '0;
    for (int i = 0; i < NPIN; i++) begin
      v[3*i+CELL_IN] = pad_in[i];
      v[3*i+CELL_OUT] = core_out[i];
      v[3*i+CELL_OE] = core_oe[i];
    end
    return v;
  endfunction
  // pins expected from a cell image, as {enables, outputs}
  function automatic logic [127:0] drive(input logic [127:0] v);
    logic [127:0] p = '0;
    for (int i = 0; i < NPIN; i++) begin
      p[i] = v[3*i+CELL_OUT];
      p[NPIN+i] = v[3*i+CELL_OE];
    end
    return p;
  endfunction

  initial begin
    logic [31:0] t;
    logic [127:0] e;
    int s0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t = rnd();
    user_code_word <= rnd();
    signature_word <= t[15:0];
    for (int k = 0; k < 6; k++) begin
      t = rnd();
      @(posedge ref_clk);
      user_tdo_out <= t[0];
      user_tdo_oe <= t[1];
      u_jbs_master.scan(1'b0, 2, 128'(t), dout);
      check(128'({tdo_oe, tdo_out}), 128'({user_tdo_oe, user_tdo_out}), "user tdo");
    end
    @(posedge ref_clk);
    port_en <= 1'b1;
    pad_in <= rnd();
    core_out <= rnd();
    core_oe <= rnd();
    u_jbs_master.tap_reset();
    dr(WORD_LEN);
    check(dout, 128'({ID_VERSION, ID_PART, ID_MAKER, 1'b1}), "idcode");
    for (int k = 0; k < 4; k++) begin
      load_ir(ops[k]);
      dr(lens[k]);
      e = k == 0 ? 128'(user_code_word) : k == 1 ? 128'(signature_word) : (din << 1) & 128'hFF;
      check(dout, e, "dr path");
    end
    load_ir(OP_SAMPLE);
    dr(BSR_LEN_DEFAULT);
    pre = din;
    check(dout, cap(), "sample");
    check(128'({pad_oe, pad_out}), 128'({core_oe, core_out}), "pins");
    load_ir(OP_EXTEST);
    repeat (5) @(negedge ref_clk);
    check(128'({pad_oe, pad_out}), drive(pre), "preload");
    dr(BSR_LEN_DEFAULT);
    repeat (5) @(negedge ref_clk);
    check(dout, cap(), "extest capture");
    check(128'({pad_oe, pad_out}), drive(din), "extest drive");
    load_ir(10'h2AB);
    s0 = strobes;
    dr(ISP_LEN);
    isp_q.push_back(din[ISP_LEN-1:0]);
    dr(ISP_LEN);
    repeat (5) @(negedge ref_clk);
    check(dout, 128'(isp_q.pop_front()), "isp reload");
    e = 128'({1'b1, 10'h2AB, din[ISP_LEN-1:0]});
    check(128'({isp_mode, isp_opcode, isp_word}), e, "isp");
    check(128'(strobes - s0), 128'h2, "isp strobes");
    load_ir(OP_BYPASS);
    check(128'(isp_mode), 128'h0, "isp exit");
    test_done();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    $display("[ERR] %0t timeout", $time);
    test_done();
  end
endmodule
`default_nettype wire
